// ===== core/emx_pin_mux.sv
// Pin mux top: strap-selected routing of shared pins and selection register
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module emx_pin_mux (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Register port
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic irq,
	// Straps
	input wire logic host_mode_strap,
	input wire logic serial_mode_strap,
	// Parallel port pins
	input wire logic [19:0] par_addr_in,
	output logic [19:0] par_addr_out,
	output logic [19:0] par_addr_oe,
	input wire logic [31:0] par_data_in,
	output logic [31:0] par_data_out,
	output logic [31:0] par_data_oe,
	input wire logic [15:0] par_ctrl_in,
	output logic [15:0] par_ctrl_out,
	output logic [15:0] par_ctrl_oe,
	// Host port pins, control bit 0 and 1 are pins zero and one
	input wire logic [7:0] host_data_pins_in,
	output logic [7:0] host_data_pins_out,
	output logic [7:0] host_data_pins_oe,
	input wire logic [1:0] host_control_pins_in,
	output logic [1:0] host_control_pins_out,
	output logic [1:0] host_control_pins_oe,
	// Serial mux pins 0 to 3
	input wire logic [3:0] serial_mux_pins_in,
	output logic [3:0] serial_mux_pins_out,
	output logic [3:0] serial_mux_pins_oe,
	// External memory interface side
	input wire logic [19:0] emi_addr_out,
	input wire logic [19:0] emi_addr_oe,
	input wire logic [31:0] emi_data_out,
	input wire logic [31:0] emi_data_oe,
	input wire logic [15:0] emi_ctrl_out,
	input wire logic [15:0] emi_ctrl_oe,
	output logic [31:0] emi_data_in,
	output logic [15:0] emi_ctrl_in,
	output logic emi_clk_en,
	input wire logic emi_access,
	// Host port side
	output logic [15:0] host_addr_in,
	input wire logic [15:0] host_data_out,
	input wire logic host_data_oe,
	output logic [15:0] host_data_in,
	output logic host_addr_strobe,
	output logic byte_half_indicator,
	output logic host_wide_mode,
	// Parallel general-purpose I/O side
	input wire logic [45:0] parallel_general_io_out,
	input wire logic [45:0] parallel_general_io_oe,
	output logic [45:0] parallel_general_io_in,
	// UART side
	input wire logic uart_tx,
	output logic uart_rx,
	output logic uart_clk_en,
	input wire logic uart_access,
	// General-purpose pins three and five
	input wire logic general_pin_three_out,
	input wire logic general_pin_three_oe,
	output logic general_pin_three_in,
	input wire logic general_pin_five_out,
	input wire logic general_pin_five_oe,
	output logic general_pin_five_in,
	// Serial port side: transmit clock, receive clock, frame syncs
	input wire logic [3:0] bsp_out,
	input wire logic [3:0] bsp_oe,
	output logic [3:0] bsp_in,
	output logic bsp_clk_en,
	input wire logic bsp_access,
	// Bus error pulse
	output logic bus_error
);

	typedef struct packed {
		emx_pkg::emx_pins_t pin_s1;
		emx_pkg::emx_pins_t pin_s2;
		logic ready;
		logic mode_host;
		logic mode_serial;
		logic rsvd_rw;
		logic timeout_en;
		logic [emx_pkg::EV_W-1:0] status;
		logic [emx_pkg::EV_W-1:0] irq_en;
		logic irq;
		logic bus_error;
		logic [15:0] rdata;
		logic [19:0] pa_out;
		logic [19:0] pa_oe;
		logic [31:0] pd_out;
		logic [31:0] pd_oe;
		logic [15:0] pc_out;
		logic [15:0] pc_oe;
		logic [7:0] hd_out;
		logic [7:0] hd_oe;
		logic [1:0] hc_out;
		logic [1:0] hc_oe;
		logic [3:0] sp_out;
		logic [3:0] sp_oe;
		logic [31:0] emi_d_in;
		logic [15:0] emi_c_in;
		logic emi_ck;
		logic [15:0] h_addr;
		logic [15:0] h_data;
		logic h_strobe;
		logic h_half;
		logic h_wide;
		logic [45:0] pg_in;
		logic u_rx;
		logic u_ck;
		logic gp3_in;
		logic gp5_in;
		logic [3:0] b_in;
		logic b_ck;
	} emx_state_t;

	emx_state_t r;
	emx_state_t n;
	emx_pkg::emx_pins_t pins_now;
	emx_pkg::emx_pins_t p;
	logic [1:0] strap_level;
	logic strap_take;
	logic [emx_pkg::EV_W-1:0] ev;

	////////////////////////////////////////////////////////////////////////
	// Straps are caught after reset release, never by the reset itself
	emx_strap_sampler u_strap (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.strap_pins({serial_mode_strap, host_mode_strap}),
		.strap_level(strap_level),
		.strap_take(strap_take)
	);

	assign pins_now = '{ctrl: par_ctrl_in, data: par_data_in,
		addr: par_addr_in, hc: host_control_pins_in,
		hd: host_data_pins_in, sp: serial_mux_pins_in};
	assign p = r.pin_s2;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		n = r;
		n.pin_s1 = pins_now;
		n.pin_s2 = r.pin_s1;
		// Errors: access to a module that the selection has turned off
		ev = '0;
		ev[emx_pkg::EV_MEM] = emi_access & ~r.mode_host;
		ev[emx_pkg::EV_UART] = uart_access & r.mode_serial;
		ev[emx_pkg::EV_BSP] = bsp_access & ~r.mode_serial;
		ev = ev & {emx_pkg::EV_W{r.timeout_en}};
		n.bus_error = |ev;
		n.status = r.status | ev;
		// Mode writes are honoured but unsupported after reset
		if (reg_wr) begin
			unique case (reg_addr)
				emx_pkg::ADDR_SELECT: begin
					n.mode_host = reg_wdata[emx_pkg::BIT_HOST_MODE];
					n.mode_serial = reg_wdata[emx_pkg::BIT_SERIAL_MODE];
					n.rsvd_rw = reg_wdata[emx_pkg::BIT_RSVD_RW];
				end
				emx_pkg::ADDR_TIMEOUT: begin
					n.timeout_en = reg_wdata[emx_pkg::BIT_TIMEOUT_EN];
				end
				emx_pkg::ADDR_CLEAR: begin
					// New events in the same cycle win over the clear
					n.status = (r.status & ~reg_wdata[emx_pkg::EV_W-1:0]) | ev;
				end
				emx_pkg::ADDR_ENABLE: begin
					n.irq_en = reg_wdata[emx_pkg::EV_W-1:0];
				end
				default: begin
					n.status = n.status;
				end
			endcase
		end
		if (strap_take) begin
			n.mode_host = strap_level[emx_pkg::STRAP_HOST];
			n.mode_serial = strap_level[emx_pkg::STRAP_SERIAL];
			n.ready = 1'b1;
		end
		n.irq = |(n.status & n.irq_en);
		n.rdata = '0;
		if (reg_rd) begin
			unique case (reg_addr)
				emx_pkg::ADDR_SELECT: begin
					n.rdata[emx_pkg::BIT_HOST_MODE] = r.mode_host;
					n.rdata[emx_pkg::BIT_SERIAL_MODE] = r.mode_serial;
					n.rdata[emx_pkg::BIT_RSVD_RW] = r.rsvd_rw;
				end
				emx_pkg::ADDR_TIMEOUT: begin
					n.rdata[emx_pkg::BIT_TIMEOUT_EN] = r.timeout_en;
				end
				emx_pkg::ADDR_STATUS: begin
					n.rdata[emx_pkg::EV_W-1:0] = r.status;
				end
				emx_pkg::ADDR_ENABLE: begin
					n.rdata[emx_pkg::EV_W-1:0] = r.irq_en;
				end
				default: begin
					n.rdata = '0;
				end
			endcase
		end
		// Pin routing; everything stays undriven until the straps are in
		n.pa_out = '0;
		n.pa_oe = '0;
		n.pd_out = '0;
		n.pd_oe = '0;
		n.pc_out = '0;
		n.pc_oe = '0;
		n.hd_out = '0;
		n.hd_oe = '0;
		n.hc_out = '0;
		n.hc_oe = '0;
		n.sp_out = '0;
		n.sp_oe = '0;
		n.emi_d_in = '0;
		n.emi_c_in = '0;
		n.h_addr = '0;
		n.h_data = '0;
		n.h_strobe = 1'b0;
		n.h_half = 1'b0;
		n.pg_in = '0;
		n.u_rx = emx_pkg::UART_RX_IDLE;
		n.gp3_in = 1'b0;
		n.gp5_in = 1'b0;
		n.b_in = '0;
		n.emi_ck = r.ready & r.mode_host;
		n.u_ck = r.ready & ~r.mode_serial;
		n.b_ck = r.ready & r.mode_serial;
		n.h_wide = r.ready & ~r.mode_host;
		if (r.ready && r.mode_host) begin
			n.pa_out = emi_addr_out;
			n.pa_oe = emi_addr_oe;
			n.pd_out = emi_data_out;
			n.pd_oe = emi_data_oe;
			n.pc_out = emi_ctrl_out;
			n.pc_oe = emi_ctrl_oe;
			n.emi_d_in = p.data;
			n.emi_c_in = p.ctrl;
			n.hd_out = host_data_out[emx_pkg::HOST_PIN_W-1:0];
			n.hd_oe = {emx_pkg::HOST_PIN_W{host_data_oe}};
			n.h_data[emx_pkg::HOST_PIN_W-1:0] = p.hd;
			n.h_strobe = p.hc[emx_pkg::HC_STROBE];
			n.h_half = p.hc[emx_pkg::HC_HALF];
		end else if (r.ready) begin
			n.h_addr = p.addr[emx_pkg::HOST_ADDR_W-1:0];
			n.h_data = p.data[emx_pkg::HOST_DATA_W-1:0];
			n.pd_out[emx_pkg::HOST_DATA_W-1:0] = host_data_out;
			n.pd_oe[emx_pkg::HOST_DATA_W-1:0] =
				{emx_pkg::HOST_DATA_W{host_data_oe}};
			n.pg_in = {p.hc, p.hd, p.ctrl,
				p.data[emx_pkg::PAR_DATA_W-1:emx_pkg::HOST_DATA_W],
				p.addr[emx_pkg::PAR_ADDR_W-1:emx_pkg::HOST_ADDR_W]};
			{n.hc_out, n.hd_out, n.pc_out,
				n.pd_out[emx_pkg::PAR_DATA_W-1:emx_pkg::HOST_DATA_W],
				n.pa_out[emx_pkg::PAR_ADDR_W-1:emx_pkg::HOST_ADDR_W]} =
				parallel_general_io_out;
			{n.hc_oe, n.hd_oe, n.pc_oe,
				n.pd_oe[emx_pkg::PAR_DATA_W-1:emx_pkg::HOST_DATA_W],
				n.pa_oe[emx_pkg::PAR_ADDR_W-1:emx_pkg::HOST_ADDR_W]} =
				parallel_general_io_oe;
		end
		if (r.ready && r.mode_serial) begin
			n.sp_out = bsp_out;
			n.sp_oe = bsp_oe;
			n.b_in = p.sp;
		end else if (r.ready) begin
			n.sp_out[emx_pkg::SER_P0] = general_pin_three_out;
			n.sp_oe[emx_pkg::SER_P0] = general_pin_three_oe;
			n.sp_out[emx_pkg::SER_P2] = general_pin_five_out;
			n.sp_oe[emx_pkg::SER_P2] = general_pin_five_oe;
			n.gp3_in = p.sp[emx_pkg::SER_P0];
			n.gp5_in = p.sp[emx_pkg::SER_P2];
			n.sp_out[emx_pkg::SER_P1] = uart_tx;
			n.sp_oe[emx_pkg::SER_P1] = 1'b1;
			n.u_rx = p.sp[emx_pkg::SER_P3];
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			r <= '{timeout_en: emx_pkg::TIMEOUT_EN_RESET,
				u_rx: emx_pkg::UART_RX_IDLE, default: '0};
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign reg_rdata = r.rdata;
	assign irq = r.irq;
	assign par_addr_out = r.pa_out;
	assign par_addr_oe = r.pa_oe;
	assign par_data_out = r.pd_out;
	assign par_data_oe = r.pd_oe;
	assign par_ctrl_out = r.pc_out;
	assign par_ctrl_oe = r.pc_oe;
	assign host_data_pins_out = r.hd_out;
	assign host_data_pins_oe = r.hd_oe;
	assign host_control_pins_out = r.hc_out;
	assign host_control_pins_oe = r.hc_oe;
	assign serial_mux_pins_out = r.sp_out;
	assign serial_mux_pins_oe = r.sp_oe;
	assign emi_data_in = r.emi_d_in;
	assign emi_ctrl_in = r.emi_c_in;
	assign emi_clk_en = r.emi_ck;
	assign host_addr_in = r.h_addr;
	assign host_data_in = r.h_data;
	assign host_addr_strobe = r.h_strobe;
	assign byte_half_indicator = r.h_half;
	assign host_wide_mode = r.h_wide;
	assign parallel_general_io_in = r.pg_in;
	assign uart_rx = r.u_rx;
	assign uart_clk_en = r.u_ck;
	assign general_pin_three_in = r.gp3_in;
	assign general_pin_five_in = r.gp5_in;
	assign bsp_in = r.b_in;
	assign bsp_clk_en = r.b_ck;
	assign bus_error = r.bus_error;

	////////////////////////////////////////////////////////////////////////
	AST_HOST_STRAP: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		strap_take |=> r.mode_host == $past(strap_level[0]) && r.ready)
		else $error("host mode not taken from strap");
	AST_SERIAL_STRAP: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		strap_take |=> r.mode_serial == $past(strap_level[1]))
		else $error("serial mode not taken from strap");
	AST_GPIO_HOST_PINS: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		r.ready && !r.mode_host |=>
		parallel_general_io_in[45:36] == $past({p.hc, p.hd}))
		else $error("host pins not routed to parallel gpio");
	AST_MUX_HOST_DATA: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		r.ready && r.mode_host |=>
		host_data_pins_out == $past(host_data_out[7:0]) &&
		host_addr_strobe == $past(p.hc[0]))
		else $error("multiplexed host pins misrouted");
	AST_WIDE_HOST: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		r.ready |=> host_wide_mode == !$past(r.mode_host) &&
		host_addr_in == ($past(r.mode_host) ? 16'h0 : $past(p.addr[15:0])))
		else $error("wide host mode misrouted");
	AST_UART_PINS: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		r.ready && !r.mode_serial |=> serial_mux_pins_oe[1] &&
		serial_mux_pins_out[1] == $past(uart_tx) &&
		uart_rx == $past(p.sp[3]))
		else $error("uart pins misrouted");
	AST_BSP_PINS: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		r.ready && r.mode_serial |=>
		serial_mux_pins_out == $past(bsp_out) && bsp_in == $past(p.sp))
		else $error("serial port pins misrouted");
	AST_CLOCK_GATE: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		r.ready |=> uart_clk_en != bsp_clk_en &&
		emi_clk_en == $past(r.mode_host))
		else $error("clock enables disagree with selection");
	AST_BUS_ERROR: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		uart_access && r.mode_serial && r.timeout_en |=> bus_error ##1
		r.status[1])
		else $error("disabled uart access gave no error");
	AST_NO_ERROR_OFF: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		!r.timeout_en |=> !bus_error)
		else $error("bus error with timeout disabled");

endmodule // emx_pin_mux

// ===== core/emx_pkg.sv
// Package: register map, field positions, pin groups and state codes
package emx_pkg;

	// Register port
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam logic [15:0] ADDR_SELECT = 16'h6C00;
	localparam logic [15:0] ADDR_TIMEOUT = 16'h6C01;
	localparam logic [15:0] ADDR_STATUS = 16'h6C02;
	localparam logic [15:0] ADDR_CLEAR = 16'h6C03;
	localparam logic [15:0] ADDR_ENABLE = 16'h6C04;

	// Selection and timeout register fields
	localparam int BIT_HOST_MODE = 0;
	localparam int BIT_SERIAL_MODE = 2;
	localparam int BIT_RSVD_RW = 3;
	localparam int BIT_TIMEOUT_EN = 0;
	localparam logic TIMEOUT_EN_RESET = 1'b0;

	// Event bits: one per module that can be deselected
	localparam int EV_W = 3;
	localparam int EV_MEM = 0;
	localparam int EV_UART = 1;
	localparam int EV_BSP = 2;

	// Pin groups
	localparam int PAR_ADDR_W = 20;
	localparam int PAR_DATA_W = 32;
	localparam int PAR_CTRL_W = 16;
	localparam int HOST_ADDR_W = 16;
	localparam int HOST_DATA_W = 16;
	localparam int HOST_PIN_W = 8;
	localparam int HOST_CTRL_W = 2;
	localparam int SER_W = 4;
	localparam int PGIO_W = 46;
	localparam int SER_P0 = 0;
	localparam int SER_P1 = 1;
	localparam int SER_P2 = 2;
	localparam int SER_P3 = 3;
	localparam int HC_STROBE = 0;
	localparam int HC_HALF = 1;
	localparam logic UART_RX_IDLE = 1'b1;

	// Strap sampling: cycles the synchroniser needs before capture
	localparam logic [1:0] SETTLE_CYCLES = 2'h2;
	localparam int STRAP_HOST = 0;
	localparam int STRAP_SERIAL = 1;

	// All pin inputs, passed together through one synchroniser
	typedef struct packed {
		logic [PAR_CTRL_W-1:0] ctrl;
		logic [PAR_DATA_W-1:0] data;
		logic [PAR_ADDR_W-1:0] addr;
		logic [HOST_CTRL_W-1:0] hc;
		logic [HOST_PIN_W-1:0] hd;
		logic [SER_W-1:0] sp;
	} emx_pins_t;

	typedef enum logic [2:0] {
		SAMP_SETTLE = 3'h1,
		SAMP_CAPTURE = 3'h2,
		SAMP_DONE = 3'h4
	} emx_samp_state_t;

endpackage

// ===== core/emx_strap_sampler.sv
// Strap sampler: synchronises the two straps and captures them once
`timescale 1ns/1ps
module emx_strap_sampler (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Strap pins
	input wire logic [1:0] strap_pins,
	// Captured levels and one-cycle capture pulse
	output logic [1:0] strap_level,
	output logic strap_take
);

	typedef struct packed {
		emx_pkg::emx_samp_state_t state;
		logic [1:0] cnt;
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] lvl;
		logic take;
	} emx_samp_t;

	emx_samp_t r;
	emx_samp_t n;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		n = r;
		n.s1 = strap_pins;
		n.s2 = r.s1;
		n.take = 1'b0;
		unique case (r.state)
			emx_pkg::SAMP_SETTLE: begin
				// Synchroniser resets to zero, so wait until real levels arrive
				n.cnt = r.cnt + 2'h1;
				if (r.cnt == emx_pkg::SETTLE_CYCLES - 2'h1) begin
					n.state = emx_pkg::SAMP_CAPTURE;
				end
			end
			emx_pkg::SAMP_CAPTURE: begin
				n.lvl = r.s2;
				n.take = 1'b1;
				n.state = emx_pkg::SAMP_DONE;
			end
			emx_pkg::SAMP_DONE: begin
				n.state = emx_pkg::SAMP_DONE;
			end
			default: begin
				n.state = emx_pkg::SAMP_SETTLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			r <= '{state: emx_pkg::SAMP_SETTLE, default: '0};
		end else begin
			r <= n;
		end
	end

	assign strap_level = r.lvl;
	assign strap_take = r.take;

	AST_ONE_CAPTURE: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		r.take |=> !r.take [*8])
		else $error("strap captured more than once");

endmodule // emx_strap_sampler

// ===== testbench/emx_far_side.sv
// Far-side model: external host, memory and serial devices on shared pins
`timescale 1ns/1ps
module emx_far_side (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Levels that the external devices put on the pins
	input wire logic drv,
	input wire logic [81:0] pat,
	// Drive of the design
	input wire logic [81:0] pin_out,
	input wire logic [81:0] pin_oe,
	// Resolved wire levels
	output logic [81:0] pin_in
);
	logic [81:0] flt_reg;

	// Released pins swing every cycle so a stale level never looks like data
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			flt_reg <= 82'h0;
		end else begin
			flt_reg <= ~flt_reg;
		end
	end

	always_comb begin
		pin_in = (pin_oe & pin_out) | (~pin_oe & (drv ? pat : flt_reg));
	end
endmodule // emx_far_side

// ===== testbench/emx_pin_mux_bench.sv
// Self-checking bench for the strap-selected pin mux
`timescale 1ns/1ps
module emx_pin_mux_bench;
	logic ref_clk, nrst, reg_wr, reg_rd, irq, host_mode_strap;
	logic serial_mode_strap, emi_clk_en, host_data_oe, host_addr_strobe;
	logic byte_half_indicator, host_wide_mode, uart_tx, uart_rx, uart_clk_en;
	logic general_pin_three_out, general_pin_three_oe, general_pin_three_in;
	logic general_pin_five_out, general_pin_five_oe, general_pin_five_in;
	logic bsp_clk_en, bus_error, drv, h, s;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, emi_ctrl_out, emi_ctrl_oe;
	logic [15:0] emi_ctrl_in, par_ctrl_out, par_ctrl_oe, host_addr_in;
	logic [15:0] host_data_out, host_data_in;
	logic [19:0] par_addr_out, par_addr_oe, emi_addr_out, emi_addr_oe;
	logic [31:0] par_data_out, par_data_oe, emi_data_out, emi_data_oe;
	logic [31:0] emi_data_in;
	logic [7:0] host_data_pins_out, host_data_pins_oe;
	logic [1:0] host_control_pins_out, host_control_pins_oe;
	logic [3:0] serial_mux_pins_out, serial_mux_pins_oe, bsp_out, bsp_oe;
	logic [3:0] bsp_in;
	logic [45:0] parallel_general_io_out, parallel_general_io_oe;
	logic [45:0] parallel_general_io_in;
	logic [81:0] pat, pin_in;
	logic [2:0] acc_v, m;
	wire logic [19:0] par_addr_in;
	wire logic [31:0] par_data_in;
	wire logic [15:0] par_ctrl_in;
	wire logic [7:0] host_data_pins_in;
	wire logic [1:0] host_control_pins_in;
	wire logic [3:0] serial_mux_pins_in;
	wire logic emi_access = acc_v[emx_pkg::EV_MEM];
	wire logic uart_access = acc_v[emx_pkg::EV_UART];
	wire logic bsp_access = acc_v[emx_pkg::EV_BSP];
	int error_cnt = 0;
	int n_compared = 0;
	int seed = 42284;

	assign {par_addr_in, par_data_in, par_ctrl_in, host_data_pins_in,
		host_control_pins_in, serial_mux_pins_in} = pin_in;

	emx_pin_mux dut (.*);

	emx_far_side far (.ref_clk(ref_clk), .nrst(nrst), .drv(drv), .pat(pat),
		.pin_out({par_addr_out, par_data_out, par_ctrl_out, host_data_pins_out,
			host_control_pins_out, serial_mux_pins_out}),
		.pin_oe({par_addr_oe, par_data_oe, par_ctrl_oe, host_data_pins_oe,
			host_control_pins_oe, serial_mux_pins_oe}),
		.pin_in(pin_in));

	initial begin
		ref_clk = 1'h0;
		forever #50 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] exp_sel(input logic hm, input logic sm);
		return {13'h0, sm, 1'h0, hm};
	endfunction

	// Modules left out by the straps
	function automatic logic [2:0] exp_off(input logic hm, input logic sm);
		logic [2:0] v;
		v[emx_pkg::EV_MEM] = !hm;
		v[emx_pkg::EV_UART] = sm;
		v[emx_pkg::EV_BSP] = !sm;
		return v;
	endfunction

	function automatic logic [351:0] rnd();
		logic [351:0] v;
		for (int j = 0; j < 11; j++) begin
			v[j*32+:32] = $random(seed);
		end
		return v;
	endfunction

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %0h, expected %0h", $time, got, exp);
		end
	endtask

	task automatic put(input logic [351:0] v);
		{emi_addr_out, emi_addr_oe, emi_data_out, emi_data_oe, emi_ctrl_out,
			emi_ctrl_oe, host_data_out, host_data_oe, parallel_general_io_out,
			parallel_general_io_oe, uart_tx, general_pin_three_out,
			general_pin_three_oe, general_pin_five_out, general_pin_five_oe,
			bsp_out, bsp_oe} <= v[257:0];
		pat <= v[339:258];
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		@(negedge ref_clk);
		chk(reg_rdata, exp);
	endtask

	task automatic acc(input int k, input logic exp);
		@(posedge ref_clk);
		acc_v[k] <= 1'h1;
		@(posedge ref_clk);
		acc_v[k] <= 1'h0;
		@(negedge ref_clk);
		chk(bus_error, exp);
	endtask

	task automatic settle();
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask

	task automatic end_of_test();
		$display("compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// About 80 cycles per strap setting; the limit leaves a wide margin
	initial begin
		#2000000;
		error_cnt++;
		end_of_test();
	end

	initial begin
		nrst = 1'h0;
		{reg_addr, reg_wdata, reg_wr, reg_rd, drv, acc_v} = 38'h0;
		{host_mode_strap, serial_mode_strap} = 2'h0;
		put(352'h0);
		for (int i = 0; i < 6; i++) begin
			{s, h} = (i < 4) ? i[1:0] : 2'($random(seed));
			@(posedge ref_clk);
			nrst <= 1'h0;
			drv <= 1'h0;
			host_mode_strap <= h;
			serial_mode_strap <= s;
			repeat (20) @(posedge ref_clk);
			nrst <= 1'h1;
			repeat (6) @(posedge ref_clk);
			// Straps move after capture; the modes must not follow
			host_mode_strap <= !h;
			serial_mode_strap <= !s;
			repeat (4) @(posedge ref_clk);
			rd(emx_pkg::ADDR_SELECT, exp_sel(h, s));
			rd(emx_pkg::ADDR_TIMEOUT, 16'h0);
			wr(emx_pkg::ADDR_SELECT, 16'hFFF2 | exp_sel(h, s));
			rd(emx_pkg::ADDR_SELECT, exp_sel(h, s));
			rd(16'h6C05, 16'h0);
			@(posedge ref_clk);
			put(rnd());
			drv <= 1'h1;
			repeat (6) @(posedge ref_clk);
			@(negedge ref_clk);
			if (h) begin
				chk(par_addr_out & par_addr_oe, emi_addr_out & emi_addr_oe);
				chk({par_data_oe, par_ctrl_oe}, {emi_data_oe, emi_ctrl_oe});
				chk({emi_data_in, emi_ctrl_in}, {par_data_in, par_ctrl_in});
				chk(host_data_pins_out & host_data_pins_oe,
					host_data_out[7:0] & {8{host_data_oe}});
				chk({byte_half_indicator, host_addr_strobe},
					host_control_pins_in);
				chk({host_addr_in, host_data_in},
					{24'h0, host_data_pins_in});
				chk({host_wide_mode, emi_clk_en}, 2'h1);
			end else begin
				chk(host_data_pins_out & host_data_pins_oe,
					parallel_general_io_out[43:36] &
					parallel_general_io_oe[43:36]);
				chk(host_control_pins_oe, parallel_general_io_oe[45:44]);
				chk(parallel_general_io_in[45:36],
					{host_control_pins_in, host_data_pins_in});
				chk({host_addr_in, host_data_in},
					{par_addr_in[15:0], par_data_in[15:0]});
				chk(par_data_oe[15:0], {16{host_data_oe}});
				chk(par_ctrl_oe, parallel_general_io_oe[35:20]);
				chk({host_wide_mode, emi_clk_en}, 2'h2);
			end
			if (s) begin
				chk(serial_mux_pins_oe, bsp_oe);
				chk(serial_mux_pins_out & bsp_oe, bsp_out & bsp_oe);
				chk(bsp_in, serial_mux_pins_in);
				chk({uart_clk_en, bsp_clk_en}, 2'h1);
			end else begin
				chk(serial_mux_pins_oe, {1'h0, general_pin_five_oe, 1'h1,
					general_pin_three_oe});
				chk(serial_mux_pins_out & serial_mux_pins_oe,
					{1'h0, general_pin_five_out & general_pin_five_oe, uart_tx,
					general_pin_three_out & general_pin_three_oe});
				chk({uart_rx, general_pin_five_in, general_pin_three_in},
					{serial_mux_pins_in[3], serial_mux_pins_in[2],
					serial_mux_pins_in[0]});
				chk({uart_clk_en, bsp_clk_en}, 2'h2);
			end
			m = exp_off(h, s);
			for (int k = 0; k < 3; k++) begin
				acc(k, 1'h0);
			end
			wr(emx_pkg::ADDR_TIMEOUT, 16'h1);
			wr(emx_pkg::ADDR_ENABLE, 16'h7);
			for (int k = 0; k < 3; k++) begin
				acc(k, m[k]);
			end
			rd(emx_pkg::ADDR_STATUS, {13'h0, m});
			chk(irq, 1'h1);
			wr(emx_pkg::ADDR_ENABLE, 16'h0);
			settle();
			chk(irq, 1'h0);
			wr(emx_pkg::ADDR_ENABLE, 16'h7);
			wr(emx_pkg::ADDR_CLEAR, {13'h0, m});
			rd(emx_pkg::ADDR_STATUS, 16'h0);
			settle();
			chk(irq, 1'h0);
		end
		end_of_test();
	end
endmodule // emx_pin_mux_bench
